// ==== pcw_pkg.sv ====
// shared constants, types and functions of the predicate compare and write unit
// Operation
// - all compare kinds write two targets from one outcome; approximations write one
// - integer compare of two sources, ten relations, in 64-bit and 32-bit forms
// - the 32-bit integer compare uses only the low 32 bits of each source
// - bit test outcome is one source bit chosen by an immediate position
// - token test outcome is the deferred token bit of the named register
// - float compare evaluates one of eight relations over two float registers
// - classify outcome is whether the value class matches any selected class
// - approximations set their one target when valid under a true qualifier and no token, otherwise clear it
// - normal type writes outcome to first target, complement to second
// - unconditional type with false qualifier writes zero to both targets
// - a false qualifier otherwise leaves every guard bit untouched, except an approximation's target, which is cleared
// - a guard bit of zero means false and one means true
// - DeMorgan type is OR behaviour on one target, AND on the complement for the other
// - several same-kind parallel compares may hit one target in one cycle
// - outside the token test, a source deferred token makes both targets zero or unchanged, by type
// - classify takes the same token handling when the token class is untested
// - broadside transfers map guard bit N to general register bit N
// - masked load writes bits 1 to 15 singly, 16 to 63 together, when mask set
// - guard bit zero always reads one and no write changes it
// - rotating load sign-extends a 28-bit immediate into bits 16 to 63
// - read-out copies the whole guard file into a general register at once
// - broadside transfers ignore the rotation base, as if it were zero
package pcw_pkg;

  // ==========================================================
  // sizes and positions
  localparam int unsigned NSLOT        = 2;
  localparam int unsigned NPRED        = 64;
  localparam int unsigned IDXW         = 6;
  localparam int unsigned ROT_FIRST    = 16;
  localparam int unsigned ROT_COUNT    = 48;
  localparam int unsigned ROT_IMM_W    = 28;
  localparam int unsigned STATIC_LAST  = 15;
  localparam int unsigned MASK_W       = 17;
  localparam int unsigned MASK_ROT_BIT = 16;
  localparam int unsigned CLASS_W      = 9;
  localparam int unsigned FLOAT_DEFERRED_TOKEN_CLASS = 8;
  localparam int unsigned NARROW_W     = 32;

  // ==========================================================
  // reset values
  localparam logic [63:0] GUARD_RST    = 64'h0000_0000_0000_0001;
  localparam logic [63:0] READOUT_RST  = 64'h0000_0000_0000_0000;

  // ==========================================================
  // encodings
  typedef enum logic [2:0] {
    OP_ICMP64 = 3'h0, OP_ICMP32 = 3'h1, OP_TBIT = 3'h2, OP_TNAT = 3'h3,
    OP_FCMP = 3'h4, OP_FCLASS = 3'h5, OP_APPROX = 3'h6
  } pcw_op_t;

  typedef enum logic [2:0] {
    CT_NORMAL = 3'h0, CT_UNC = 3'h1, CT_AND = 3'h2, CT_OR = 3'h3, CT_DEMORGAN = 3'h4
  } pcw_ctype_t;

  typedef enum logic [3:0] {
    IR_EQ = 4'h0, IR_NE = 4'h1, IR_LT = 4'h2, IR_LE = 4'h3, IR_GT = 4'h4,
    IR_GE = 4'h5, IR_LTU = 4'h6, IR_LEU = 4'h7, IR_GTU = 4'h8, IR_GEU = 4'h9
  } pcw_irel_t;

  typedef enum logic [2:0] {
    FR_EQ = 3'h0, FR_LT = 3'h1, FR_LE = 3'h2, FR_UNORD = 3'h3,
    FR_NEQ = 3'h4, FR_NLT = 3'h5, FR_NLE = 3'h6, FR_ORD = 3'h7
  } pcw_frel_t;

  typedef enum logic [1:0] {
    XF_NONE = 2'h0, XF_MASKED = 2'h1, XF_ROT_IMM = 2'h2, XF_READ_OUT = 2'h3
  } pcw_xfer_t;

  // ==========================================================
  // integer relation over full or low-half operands
  function automatic logic int_rel(input pcw_irel_t rel, input logic [63:0] a,
                                   input logic [63:0] b, input logic narrow);
    logic [63:0] ua;
    logic [63:0] ub;
    logic        sa;
    logic        sb;
    logic        eq;
    logic        ltu;
    logic        lts;
    logic        res;
    ua  = narrow ? {32'h0000_0000, a[31:0]} : a;
    ub  = narrow ? {32'h0000_0000, b[31:0]} : b;
    sa  = narrow ? a[31] : a[63];
    sb  = narrow ? b[31] : b[63];
    eq  = (ua == ub);
    ltu = (ua < ub);
    // differing signs decide a signed order on their own
    lts = (sa != sb) ? sa : ltu;
    unique case (rel)
      IR_EQ:   res = eq;
      IR_NE:   res = !eq;
      IR_LT:   res = lts;
      IR_LE:   res = lts | eq;
      IR_GT:   res = !(lts | eq);
      IR_GE:   res = !lts;
      IR_LTU:  res = ltu;
      IR_LEU:  res = ltu | eq;
      IR_GTU:  res = !(ltu | eq);
      IR_GEU:  res = !ltu;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  // compare targets and qualifiers see the rotating bits through the base
  function automatic logic [5:0] guard_rename(input logic [5:0] idx, input logic [5:0] base);
    logic [6:0] s;
    s = 7'(idx) - 7'(ROT_FIRST) + 7'(base);
    if (idx < 6'(ROT_FIRST)) begin
      return idx;
    end
    if (s >= 7'(ROT_COUNT)) begin
      s = s - 7'(ROT_COUNT);
    end
    return 6'(s + 7'(ROT_FIRST));
  endfunction

endpackage

// ==== pcw_guard_store.sv ====
// guard bit register file storage with set, clear and broadside load
`timescale 1ns/100ps
module pcw_guard_store (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  // update masks
  input  wire logic [63:0] i_set_mask,
  input  wire logic [63:0] i_clr_mask,
  input  wire logic [63:0] i_ld_mask,
  input  wire logic [63:0] i_ld_data,
  // stored bits
  output logic      [63:0] o_bits_q
);

  logic [63:0] bits_d;

  // ==========================================================
  // next value: clear beats set, broadside load beats both
  always_comb begin
    bits_d    = (o_bits_q | i_set_mask) & ~i_clr_mask;
    bits_d    = (bits_d & ~i_ld_mask) | (i_ld_data & i_ld_mask);
    bits_d[0] = 1'b1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_bits_q <= pcw_pkg::GUARD_RST;
    end else begin
      o_bits_q <= bits_d;
    end
  end

endmodule

// ==== pcw_predicate_unit.sv ====
// predicate compare and write unit: compare outcomes and broadside guard transfers
`timescale 1ns/100ps
module pcw_predicate_unit (
  // clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_nrst,
  // compare slots of one instruction group
  input  wire logic                 i_cmp_vld   [pcw_pkg::NSLOT],
  input  wire pcw_pkg::pcw_op_t     i_cmp_op    [pcw_pkg::NSLOT],
  input  wire pcw_pkg::pcw_ctype_t  i_cmp_type  [pcw_pkg::NSLOT],
  input  wire pcw_pkg::pcw_irel_t   i_int_rel   [pcw_pkg::NSLOT],
  input  wire pcw_pkg::pcw_frel_t   i_fp_rel    [pcw_pkg::NSLOT],
  input  wire logic [63:0]          i_src_a     [pcw_pkg::NSLOT],
  input  wire logic [63:0]          i_src_b     [pcw_pkg::NSLOT],
  input  wire logic                 i_nat_a     [pcw_pkg::NSLOT],
  input  wire logic                 i_nat_b     [pcw_pkg::NSLOT],
  input  wire logic [5:0]           i_bit_pos   [pcw_pkg::NSLOT],
  input  wire logic                 i_fp_lt     [pcw_pkg::NSLOT],
  input  wire logic                 i_fp_eq     [pcw_pkg::NSLOT],
  input  wire logic                 i_fp_unord  [pcw_pkg::NSLOT],
  input  wire logic [8:0]           i_fp_class  [pcw_pkg::NSLOT],
  input  wire logic [8:0]           i_class_sel [pcw_pkg::NSLOT],
  input  wire logic                 i_approx_ok [pcw_pkg::NSLOT],
  input  wire logic [5:0]           i_qp_idx    [pcw_pkg::NSLOT],
  input  wire logic [5:0]           i_tgt1_idx  [pcw_pkg::NSLOT],
  input  wire logic [5:0]           i_tgt2_idx  [pcw_pkg::NSLOT],
  // rotation base
  input  wire logic [5:0]           i_rot_base,
  // broadside transfer
  input  wire pcw_pkg::pcw_xfer_t   i_xfer_op,
  input  wire logic [63:0]          i_xfer_gr,
  input  wire logic [16:0]          i_xfer_mask,
  input  wire logic [27:0]          i_rot_imm,
  // guard file and read-out
  output logic      [63:0]          o_guard_q,
  output logic      [63:0]          o_readout_q,
  output logic                      o_readout_vld_q
);

  localparam int unsigned NS = pcw_pkg::NSLOT;

  logic [5:0]  qp_phys  [NS];
  logic [5:0]  p1_phys  [NS];
  logic [5:0]  p2_phys  [NS];
  logic        qp_val   [NS];
  logic        res      [NS];
  logic        nat_hit  [NS];
  logic        w1e      [NS];
  logic        w1v      [NS];
  logic        w2e      [NS];
  logic        w2v      [NS];
  logic [63:0] set_m;
  logic [63:0] clr_m;
  logic [63:0] ld_m;
  logic [63:0] ld_d;
  logic [47:0] rot_ext;

  // ==========================================================
  // slot outcome
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      qp_phys[s] = pcw_pkg::guard_rename(i_qp_idx[s], i_rot_base);
      p1_phys[s] = pcw_pkg::guard_rename(i_tgt1_idx[s], i_rot_base);
      p2_phys[s] = pcw_pkg::guard_rename(i_tgt2_idx[s], i_rot_base);
      qp_val[s]  = (o_guard_q[qp_phys[s]] == 1'b1);
      res[s]     = 1'b0;
      nat_hit[s] = 1'b0;
      unique case (i_cmp_op[s])
        pcw_pkg::OP_ICMP64: begin
          res[s]     = pcw_pkg::int_rel(i_int_rel[s], i_src_a[s], i_src_b[s], 1'b0);
          nat_hit[s] = i_nat_a[s] | i_nat_b[s];
        end
        pcw_pkg::OP_ICMP32: begin
          res[s]     = pcw_pkg::int_rel(i_int_rel[s], i_src_a[s], i_src_b[s], 1'b1);
          nat_hit[s] = i_nat_a[s] | i_nat_b[s];
        end
        pcw_pkg::OP_TBIT: begin
          res[s]     = i_src_a[s][i_bit_pos[s]];
          nat_hit[s] = i_nat_a[s];
        end
        // token bit is the outcome, no token handling
        pcw_pkg::OP_TNAT: begin
          res[s]     = i_nat_a[s];
        end
        pcw_pkg::OP_FCMP: begin
          nat_hit[s] = i_nat_a[s] | i_nat_b[s];
          unique case (i_fp_rel[s])
            pcw_pkg::FR_EQ:    res[s] = i_fp_eq[s] & ~i_fp_unord[s];
            pcw_pkg::FR_LT:    res[s] = i_fp_lt[s] & ~i_fp_unord[s];
            pcw_pkg::FR_LE:    res[s] = (i_fp_lt[s] | i_fp_eq[s]) & ~i_fp_unord[s];
            pcw_pkg::FR_UNORD: res[s] = i_fp_unord[s];
            pcw_pkg::FR_NEQ:   res[s] = ~(i_fp_eq[s] & ~i_fp_unord[s]);
            pcw_pkg::FR_NLT:   res[s] = ~(i_fp_lt[s] & ~i_fp_unord[s]);
            pcw_pkg::FR_NLE:   res[s] = ~((i_fp_lt[s] | i_fp_eq[s]) & ~i_fp_unord[s]);
            pcw_pkg::FR_ORD:   res[s] = ~i_fp_unord[s];
          endcase
        end
        pcw_pkg::OP_FCLASS: begin
          res[s]     = |(i_fp_class[s] & i_class_sel[s]);
          // token counts only when its class is not tested
          nat_hit[s] = i_nat_a[s] & ~i_class_sel[s][pcw_pkg::FLOAT_DEFERRED_TOKEN_CLASS];
        end
        pcw_pkg::OP_APPROX: begin
          res[s]     = i_approx_ok[s];
          nat_hit[s] = i_nat_a[s] | i_nat_b[s];
        end
        default: begin
          res[s]     = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // per target write strobes
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      w1e[s] = 1'b0;
      w1v[s] = 1'b0;
      w2e[s] = 1'b0;
      w2v[s] = 1'b0;
      if (!i_cmp_vld[s]) begin
        w1e[s] = 1'b0;
      end else if (i_cmp_op[s] == pcw_pkg::OP_APPROX) begin
        w1e[s] = 1'b1;
        w1v[s] = qp_val[s] & ~nat_hit[s] & res[s];
      end else if ((i_cmp_type[s] == pcw_pkg::CT_UNC) && !qp_val[s]) begin
        w1e[s] = 1'b1;
        w2e[s] = 1'b1;
      end else if (qp_val[s] && nat_hit[s]) begin
        // both targets alike under a token
        if ((i_cmp_type[s] == pcw_pkg::CT_NORMAL) || (i_cmp_type[s] == pcw_pkg::CT_UNC) ||
            (i_cmp_type[s] == pcw_pkg::CT_AND)) begin
          w1e[s] = 1'b1;
          w2e[s] = 1'b1;
        end
      end else if (qp_val[s]) begin
        unique case (i_cmp_type[s])
          pcw_pkg::CT_NORMAL, pcw_pkg::CT_UNC: begin
            w1e[s] = 1'b1;
            w1v[s] = res[s];
            w2e[s] = 1'b1;
            w2v[s] = ~res[s];
          end
          pcw_pkg::CT_AND: begin
            w1e[s] = ~res[s];
            w2e[s] = ~res[s];
          end
          pcw_pkg::CT_OR: begin
            w1e[s] = res[s];
            w1v[s] = 1'b1;
            w2e[s] = res[s];
            w2v[s] = 1'b1;
          end
          // OR on the first, AND on the complement for the second
          pcw_pkg::CT_DEMORGAN: begin
            w1e[s] = res[s];
            w1v[s] = 1'b1;
            w2e[s] = res[s];
          end
          default: begin
            w1e[s] = 1'b0;
          end
        endcase
      end
      // false qualifier falls through with no strobe
    end
  end

  // ==========================================================
  // merge of all slots; same-kind writes to one bit simply or together
  always_comb begin
    set_m = '0;
    clr_m = '0;
    // parallel writes resolve in the same cycle
    for (int s = 0; s < NS; s++) begin
      if (w1e[s]) begin
        if (w1v[s]) set_m[p1_phys[s]] = 1'b1;
        else clr_m[p1_phys[s]] = 1'b1;
      end
      if (w2e[s]) begin
        if (w2v[s]) set_m[p2_phys[s]] = 1'b1;
        else clr_m[p2_phys[s]] = 1'b1;
      end
    end
  end

  // ==========================================================
  // broadside loads, physical indices only
  assign rot_ext = {{20{i_rot_imm[27]}}, i_rot_imm};

  always_comb begin
    ld_m = '0;
    ld_d = '0;
    unique case (i_xfer_op)
      pcw_pkg::XF_MASKED: begin
        ld_d = i_xfer_gr;
        // fifteen single bits and one group bit
        for (int i = 1; i <= pcw_pkg::STATIC_LAST; i++) begin
          ld_m[i] = i_xfer_mask[i];
        end
        ld_m[63:16] = {48{i_xfer_mask[pcw_pkg::MASK_ROT_BIT]}};
      end
      pcw_pkg::XF_ROT_IMM: begin
        // sign-extended immediate over the rotating bits
        ld_m[63:16] = {48{1'b1}};
        ld_d[63:16] = rot_ext;
      end
      pcw_pkg::XF_NONE, pcw_pkg::XF_READ_OUT: begin
        ld_m = '0;
      end
    endcase
  end

  pcw_guard_store u_store (
    .i_sys_clk  (i_sys_clk),
    .i_nrst     (i_nrst),
    .i_set_mask (set_m),
    .i_clr_mask (clr_m),
    .i_ld_mask  (ld_m),
    .i_ld_data  (ld_d),
    .o_bits_q   (o_guard_q)
  );

  // ==========================================================
  // read-out shows the file as it stood before this cycle's writes
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_readout_q     <= pcw_pkg::READOUT_RST;
      o_readout_vld_q <= 1'b0;
    end else begin
      o_readout_vld_q <= (i_xfer_op == pcw_pkg::XF_READ_OUT);
      if (i_xfer_op == pcw_pkg::XF_READ_OUT) begin
        o_readout_q <= o_guard_q;
      end
    end
  end

  // ==========================================================
  // checking helpers and assertions
  logic [63:0] guard_prev_q;
  logic [5:0]  chk_p1_q;
  logic [5:0]  chk_p2_q;
  logic        chk_r_q;
  logic        chk_any_r_q;
  logic        chk_ok_q;
  logic        no_ld;
  logic        quiet;
  logic        solo0;

  assign no_ld = (i_xfer_op == pcw_pkg::XF_NONE) || (i_xfer_op == pcw_pkg::XF_READ_OUT);
  assign solo0 = i_cmp_vld[0] && !i_cmp_vld[1] && no_ld && (p1_phys[0] != 6'h00) &&
                 (p2_phys[0] != 6'h00) && (p1_phys[0] != p2_phys[0]);
  assign quiet = no_ld &&
                 (!i_cmp_vld[0] || (!qp_val[0] && (i_cmp_type[0] != pcw_pkg::CT_UNC) &&
                  (i_cmp_op[0] != pcw_pkg::OP_APPROX))) &&
                 (!i_cmp_vld[1] || (!qp_val[1] && (i_cmp_type[1] != pcw_pkg::CT_UNC) &&
                  (i_cmp_op[1] != pcw_pkg::OP_APPROX)));

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      guard_prev_q <= pcw_pkg::GUARD_RST;
      chk_p1_q     <= 6'h00;
      chk_p2_q     <= 6'h00;
      chk_r_q      <= 1'b0;
      chk_any_r_q  <= 1'b0;
      chk_ok_q     <= 1'b0;
    end else begin
      guard_prev_q <= o_guard_q;
      chk_p1_q     <= p1_phys[0];
      chk_p2_q     <= p2_phys[0];
      chk_r_q      <= res[0];
      chk_any_r_q  <= res[0] | res[1];
      chk_ok_q     <= qp_val[0] & res[0] & ~nat_hit[0];
    end
  end

  a_guard_zero_one: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    ##1 o_guard_q[0] == 1'b1) else $error("guard bit zero not one");

  a_readout_copy: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_xfer_op == pcw_pkg::XF_READ_OUT |=> o_readout_vld_q && o_readout_q == $past(o_guard_q))
    else $error("read-out does not match file");

  a_rot_sign_fill: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_xfer_op == pcw_pkg::XF_ROT_IMM |=> o_guard_q[63:16] == $past(rot_ext) &&
    (&o_guard_q[63:43] || !(|o_guard_q[63:43]))) else $error("rotating load wrong");

  a_masked_group_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_xfer_op == pcw_pkg::XF_MASKED && !i_xfer_mask[16] && set_m == '0 && clr_m == '0
    |=> o_guard_q[63:16] == guard_prev_q[63:16] && o_guard_q[15:1] ==
    ((guard_prev_q[15:1] & ~$past(i_xfer_mask[15:1])) | ($past(i_xfer_gr[15:1]) &
    $past(i_xfer_mask[15:1])))) else $error("masked load wrong");

  a_qp_false_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    quiet |=> o_guard_q == $past(o_guard_q)) else $error("false qualifier changed file");

  a_normal_pair: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    solo0 && i_cmp_type[0] == pcw_pkg::CT_NORMAL && qp_val[0] && !nat_hit[0] &&
    i_cmp_op[0] != pcw_pkg::OP_APPROX
    |=> o_guard_q[chk_p1_q] == chk_r_q && o_guard_q[chk_p2_q] == !chk_r_q)
    else $error("normal compare pair wrong");

  a_unc_clear: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    solo0 && i_cmp_type[0] == pcw_pkg::CT_UNC && !qp_val[0] &&
    i_cmp_op[0] != pcw_pkg::OP_APPROX
    |=> !o_guard_q[chk_p1_q] && !o_guard_q[chk_p2_q]) else $error("unconditional not cleared");

  a_nat_and_zero: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    solo0 && i_cmp_type[0] == pcw_pkg::CT_AND && qp_val[0] && nat_hit[0] &&
    i_cmp_op[0] != pcw_pkg::OP_APPROX
    |=> !o_guard_q[chk_p1_q] && !o_guard_q[chk_p2_q]) else $error("token did not clear");

  a_or_parallel: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_cmp_vld[0] && i_cmp_vld[1] && no_ld && qp_val[0] && qp_val[1] &&
    i_cmp_type[0] == pcw_pkg::CT_OR && i_cmp_type[1] == pcw_pkg::CT_OR &&
    !nat_hit[0] && !nat_hit[1] && p1_phys[0] == p1_phys[1] && p1_phys[0] != 6'h00 &&
    i_cmp_op[0] != pcw_pkg::OP_APPROX && i_cmp_op[1] != pcw_pkg::OP_APPROX
    |=> o_guard_q[chk_p1_q] == (chk_any_r_q | guard_prev_q[chk_p1_q]))
    else $error("parallel or wrong");

  a_approx_single: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    solo0 && i_cmp_op[0] == pcw_pkg::OP_APPROX
    |=> o_guard_q[chk_p1_q] == chk_ok_q && o_guard_q[chk_p2_q] == guard_prev_q[chk_p2_q])
    else $error("approximation target wrong");

  a_int32_upper: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_cmp_op[0] == pcw_pkg::OP_ICMP32 |-> res[0] == pcw_pkg::int_rel(i_int_rel[0],
    {~i_src_a[0][63:32], i_src_a[0][31:0]}, {i_src_b[0][63:32], i_src_b[0][31:0]}, 1'b1))
    else $error("narrow compare saw upper half");

endmodule

// ==== predicate_compare_write_unit_tb.sv ====
// self-checking bench of the predicate compare and write unit
`timescale 1ns/100ps
module predicate_compare_write_unit_tb;
  // ==========================================================
  // stimulus and observed signals
  logic                i_sys_clk = 1'b0;
  logic                i_nrst    = 1'b0;
  logic                i_cmp_vld [pcw_pkg::NSLOT];
  pcw_pkg::pcw_op_t    i_cmp_op  [pcw_pkg::NSLOT];
  pcw_pkg::pcw_ctype_t i_cmp_type [pcw_pkg::NSLOT];
  pcw_pkg::pcw_irel_t  i_int_rel [pcw_pkg::NSLOT];
  pcw_pkg::pcw_frel_t  i_fp_rel  [pcw_pkg::NSLOT];
  logic [63:0]         i_src_a [pcw_pkg::NSLOT], i_src_b [pcw_pkg::NSLOT];
  logic                i_nat_a [pcw_pkg::NSLOT], i_nat_b [pcw_pkg::NSLOT];
  logic [5:0]          i_bit_pos [pcw_pkg::NSLOT];
  logic                i_fp_lt [pcw_pkg::NSLOT], i_fp_eq [pcw_pkg::NSLOT];
  logic                i_fp_unord [pcw_pkg::NSLOT], i_approx_ok [pcw_pkg::NSLOT];
  logic [8:0]          i_fp_class [pcw_pkg::NSLOT], i_class_sel [pcw_pkg::NSLOT];
  logic [5:0]          i_qp_idx [pcw_pkg::NSLOT], i_tgt1_idx [pcw_pkg::NSLOT];
  logic [5:0]          i_tgt2_idx [pcw_pkg::NSLOT];
  // a nonzero base shows that broadside transfers ignore it
  logic [5:0]          i_rot_base = 6'h05;
  pcw_pkg::pcw_xfer_t  i_xfer_op  = pcw_pkg::XF_NONE;
  logic [63:0]         i_xfer_gr  = 64'h0;
  logic [16:0]         i_xfer_mask = 17'h0;
  logic [27:0]         i_rot_imm  = 28'h0;
  logic [63:0]         o_guard_q, o_readout_q;
  logic                o_readout_vld_q;
  int                  num_errors = 0;
  int                  checks = 0;
  int                  cyc = 0;

  pcw_predicate_unit pcw_predicate_unit_i (
    .i_sys_clk, .i_nrst, .i_cmp_vld, .i_cmp_op, .i_cmp_type, .i_int_rel, .i_fp_rel,
    .i_src_a, .i_src_b, .i_nat_a, .i_nat_b, .i_bit_pos, .i_fp_lt, .i_fp_eq, .i_fp_unord,
    .i_fp_class, .i_class_sel, .i_approx_ok, .i_qp_idx, .i_tgt1_idx, .i_tgt2_idx,
    .i_rot_base, .i_xfer_op, .i_xfer_gr, .i_xfer_mask, .i_rot_imm,
    .o_guard_q, .o_readout_q, .o_readout_vld_q
  );

  always #5 i_sys_clk = ~i_sys_clk;

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one edge takes the request, the next edge idles so no signal is driven twice at once
  task automatic tick();
    @(posedge i_sys_clk);
    #1;
    i_xfer_op = pcw_pkg::XF_NONE;
    for (int s = 0; s < 2; s++) begin
      i_cmp_vld[s] = 1'b0;
      i_nat_a[s]   = 1'b0;
      i_nat_b[s]   = 1'b0;
    end
    @(posedge i_sys_clk);
    #1;
  endtask

  task automatic slot(input int s, input pcw_pkg::pcw_op_t op, input pcw_pkg::pcw_ctype_t ct,
                      input logic [63:0] a, input logic [63:0] b, input logic [5:0] qp,
                      input logic [5:0] t1, input logic [5:0] t2);
    i_cmp_vld[s]  = 1'b1;
    i_cmp_op[s]   = op;
    i_cmp_type[s] = ct;
    i_src_a[s]    = a;
    i_src_b[s]    = b;
    i_qp_idx[s]   = qp;
    i_tgt1_idx[s] = t1;
    i_tgt2_idx[s] = t2;
  endtask

  task automatic load(input logic [63:0] v);
    i_xfer_op   = pcw_pkg::XF_MASKED;
    i_xfer_mask = 17'h1ffff;
    i_xfer_gr   = v;
    tick();
  endtask

  // ==========================================================
  // scenarios
  task automatic t_xfer();
    chk(o_guard_q, 64'h1);
    chk({63'h0, o_readout_vld_q}, 64'h0);
    i_xfer_op = pcw_pkg::XF_ROT_IMM;
    i_rot_imm = 28'h8000001;
    tick();
    chk(o_guard_q, 64'hffff_f800_0001_0001);
    i_xfer_op   = pcw_pkg::XF_MASKED;
    i_xfer_mask = 17'h10009;
    i_xfer_gr   = 64'h5555_aaaa_5555_fffe;
    tick();
    chk(o_guard_q, 64'h5555_aaaa_5555_0009);
    i_xfer_op = pcw_pkg::XF_READ_OUT;
    @(posedge i_sys_clk);
    #1;
    i_xfer_op = pcw_pkg::XF_NONE;
    chk({63'h0, o_readout_vld_q}, 64'h1);
    chk(o_readout_q, 64'h5555_aaaa_5555_0009);
    @(posedge i_sys_clk);
    #1;
    chk({63'h0, o_readout_vld_q}, 64'h0);
    i_rot_base = 6'h00;
    i_xfer_op  = pcw_pkg::XF_ROT_IMM;
    i_rot_imm  = 28'h0000003;
    tick();
    chk(o_guard_q, 64'h0000_0000_0003_0009);
    i_rot_base = 6'h05;
  endtask

  task automatic t_cmp();
    load(64'h1);
    slot(0, pcw_pkg::OP_ICMP32, pcw_pkg::CT_NORMAL, 64'hffff_0000_0000_0005, 64'h5, 0, 1, 2);
    i_int_rel[0] = pcw_pkg::IR_EQ;
    slot(1, pcw_pkg::OP_ICMP64, pcw_pkg::CT_NORMAL, 64'hffff_ffff_ffff_ffff, 64'h1, 0, 3, 4);
    i_int_rel[1] = pcw_pkg::IR_LT;
    tick();
    chk(o_guard_q, 64'h0b);
    load(64'h1f);
    slot(0, pcw_pkg::OP_ICMP64, pcw_pkg::CT_NORMAL, 64'h7, 64'h7, 5, 1, 2);
    slot(1, pcw_pkg::OP_ICMP64, pcw_pkg::CT_UNC, 64'h7, 64'h7, 5, 3, 4);
    i_int_rel[1] = pcw_pkg::IR_EQ;
    tick();
    chk(o_guard_q, 64'h07);
  endtask

  task automatic t_par();
    load(64'h101);
    slot(0, pcw_pkg::OP_ICMP64, pcw_pkg::CT_OR, 64'h1, 64'h2, 0, 7, 7);
    slot(1, pcw_pkg::OP_ICMP64, pcw_pkg::CT_OR, 64'h2, 64'h2, 0, 7, 7);
    tick();
    chk(o_guard_q, 64'h181);
    slot(0, pcw_pkg::OP_ICMP64, pcw_pkg::CT_AND, 64'h2, 64'h2, 0, 8, 8);
    slot(1, pcw_pkg::OP_ICMP64, pcw_pkg::CT_AND, 64'h1, 64'h2, 0, 8, 8);
    tick();
    chk(o_guard_q, 64'h081);
    load(64'h35);
    slot(0, pcw_pkg::OP_ICMP64, pcw_pkg::CT_DEMORGAN, 64'h3, 64'h3, 0, 1, 2);
    tick();
    chk(o_guard_q, 64'h33);
    slot(0, pcw_pkg::OP_ICMP64, pcw_pkg::CT_NORMAL, 64'h3, 64'h3, 0, 4, 5);
    slot(1, pcw_pkg::OP_ICMP64, pcw_pkg::CT_OR, 64'h3, 64'h3, 0, 6, 6);
    i_nat_a[0] = 1'b1;
    i_nat_b[1] = 1'b1;
    tick();
    chk(o_guard_q, 64'h03);
  endtask

  task automatic t_misc();
    load(64'h15);
    slot(0, pcw_pkg::OP_TBIT, pcw_pkg::CT_NORMAL, 64'h1_0000, 64'h0, 0, 1, 2);
    i_bit_pos[0] = 6'h10;
    slot(1, pcw_pkg::OP_TNAT, pcw_pkg::CT_NORMAL, 64'h0, 64'h0, 0, 3, 4);
    i_nat_a[1] = 1'b1;
    tick();
    chk(o_guard_q, 64'h0b);
    slot(0, pcw_pkg::OP_FCLASS, pcw_pkg::CT_NORMAL, 64'h0, 64'h0, 0, 5, 6);
    i_fp_class[0]  = 9'h004;
    i_class_sel[0] = 9'h00c;
    slot(1, pcw_pkg::OP_APPROX, pcw_pkg::CT_NORMAL, 64'h0, 64'h0, 0, 7, 9);
    i_approx_ok[1] = 1'b1;
    tick();
    chk(o_guard_q, 64'hab);
    slot(0, pcw_pkg::OP_FCMP, pcw_pkg::CT_NORMAL, 64'h0, 64'h0, 0, 2, 1);
    i_fp_rel[0] = pcw_pkg::FR_LT;
    i_fp_lt[0]  = 1'b1;
    slot(1, pcw_pkg::OP_APPROX, pcw_pkg::CT_NORMAL, 64'h0, 64'h0, 0, 7, 9);
    i_approx_ok[1] = 1'b0;
    tick();
    chk(o_guard_q, 64'h2d);
  endtask

  // ==========================================================
  // watchdog and main sequence
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    for (int s = 0; s < 2; s++) begin
      slot(s, pcw_pkg::OP_ICMP64, pcw_pkg::CT_NORMAL, 64'h0, 64'h0, 0, 0, 0);
      i_cmp_vld[s] = 1'b0;
      {i_nat_a[s], i_nat_b[s], i_fp_lt[s], i_fp_eq[s], i_fp_unord[s]} = 5'h00;
      {i_approx_ok[s], i_bit_pos[s], i_fp_class[s], i_class_sel[s]} = 25'h0;
      i_int_rel[s] = pcw_pkg::IR_EQ;
      i_fp_rel[s]  = pcw_pkg::FR_EQ;
    end
    repeat (4) @(posedge i_sys_clk);
    #1;
    i_nrst = 1'b1;
    t_xfer();
    t_cmp();
    t_par();
    t_misc();
    wrap_up();
  end
endmodule
